// [bench/isa_bus_monitor.sv]
// --------
// bus checker
// --------
module isa_bus_monitor #(
    parameter int REFRESH_PERIOD = 40
) (
    input wire logic        clk_sys,     // clock
    input wire logic        rst_n,       // reset
    input wire logic [19:0] sa,          // address
    input wire logic [6:0]  la,          // upper address
    input wire logic        bale,        // address latch
    input wire logic        aen,         // dma cycle
    input wire logic        sbhe_n,      // high byte enable
    input wire logic        memr_n,      // mem read
    input wire logic        memw_n,      // mem write
    input wire logic        smemr_n,     // low-meg read
    input wire logic        smemw_n,     // low-meg write
    input wire logic        ior_n,       // io read
    input wire logic        iow_n,       // io write
    input wire logic        refresh_n,   // refresh
    input wire logic        dack_n,      // dma acknowledge
    input wire logic        sd_dev_oe,   // peripheral drives data
    input wire logic        iochrdy_low  // ready pulled low
);
    timeunit 1ns;
    timeprecision 1ns;
    // slack covers one fully stretched access that delays the refresh
    localparam int REF_MAX = REFRESH_PERIOD + 64;
    logic cmd_low;

    // any command strobe active
    assign cmd_low = !(memr_n && memw_n && ior_n && iow_n);

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_refresh_io_quiet: assert property (!refresh_n |-> ior_n && iow_n)
        else $error("io strobe during refresh");
    a_low_meg_read: assert property (!memr_n |-> smemr_n == (la[6:3] != 4'h0))
        else $error("low-meg read strobe wrong");
    a_low_meg_write: assert property (!memw_n |-> smemw_n == (la[6:3] != 4'h0))
        else $error("low-meg write strobe wrong");
    a_latch_single: assert property ($rose(bale) |=> !bale)
        else $error("latch pulse too long");
    a_addr_held: assert property ($fell(bale) |-> $stable(sa) && $stable(la) && $stable(sbhe_n))
        else $error("address moved at latch fall");
    a_cmd_after_latch: assert property (bale |-> !cmd_low)
        else $error("command during latch pulse");
    a_ready_holds: assert property (cmd_low && iochrdy_low |=> cmd_low)
        else $error("strobe ended while not ready");
    a_space_apart: assert property (!((!memr_n || !memw_n) && (!ior_n || !iow_n)))
        else $error("memory and io strobes together");
    a_dma_quiet: assert property (aen && dack_n |-> !sd_dev_oe)
        else $error("peripheral drove data without acknowledge");
    a_refresh_gap: assert property ($rose(refresh_n) |-> ##[1:REF_MAX] $fell(refresh_n))
        else $error("refresh overdue");

    cover property ($fell(refresh_n));
    cover property (cmd_low && iochrdy_low);
    cover property (!smemr_n);
endmodule : isa_bus_monitor

// [bench/testbench.sv]
module testbench
    import isa_cycle_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REF_P = 40;
    logic        clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_mem = 1'b0;
    logic        req_write = 1'b0, req_wide = 1'b0, req_dma = 1'b0, chk_enable = 1'b0;
    logic        is_mem = 1'b0, is_wide = 1'b0, fast = 1'b0, err = 1'b0, own_dack = 1'b0;
    logic        req_ready, done, nmi, wr_seen, seen;
    logic [3:0]  stretch = 4'h0;
    logic [23:0] req_addr = 24'h000000, base = 24'h000300;
    logic [15:0] req_wdata = 16'h0000, rdata, store, got, last, d;
    int          num_errors = 0, num_checks = 0, cyc = 0, seed = 17, ndone = 0, k;

    isa_bus_if bus ();
    isa_host #(.REFRESH_PERIOD(REF_P)) i_isa_host (.clk_sys, .rst_n, .req_valid, .req_ready,
        .req_mem, .req_write, .req_wide, .req_dma, .req_addr, .req_wdata, .chk_enable, .done,
        .rdata, .nmi, .bus(bus.host));
    isa_periph i_isa_periph (.clk_sys, .rst_n, .is_mem, .is_wide, .base, .stretch, .fast, .err,
        .own_dack, .store, .wr_seen, .bus(bus.periph));
    isa_bus_monitor #(.REFRESH_PERIOD(REF_P)) i_isa_bus_monitor (.clk_sys, .rst_n, .sa(bus.sa),
        .la(bus.la), .bale(bus.bale), .aen(bus.aen), .sbhe_n(bus.sbhe_n), .memr_n(bus.memr_n),
        .memw_n(bus.memw_n), .smemr_n(bus.smemr_n), .smemw_n(bus.smemw_n), .ior_n(bus.ior_n),
        .iow_n(bus.iow_n), .refresh_n(bus.refresh_n), .dack_n(bus.dack_n),
        .sd_dev_oe(bus.sd_dev_oe), .iochrdy_low(bus.iochrdy_low));

    always #50 clk_sys = ~clk_sys;

    // count retired accesses and keep their read data; a hang ends the run
    always @(posedge clk_sys) begin
        cyc++;
        if (done === 1'b1) begin
            ndone++;
            last = rdata;
        end
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic check(input logic [15:0] g, e, m);
        num_checks++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : check

    // wait for a given count of retired accesses, bounded
    task automatic wait_done(input int t);
        k = 0;
        while (ndone < t && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
        if (ndone < t) begin
            num_errors++;
            $display("unexpected at %0t: access never finished", $time);
        end
        got = last;
    endtask : wait_done

    // one request held until taken, then its completion
    task automatic xfer(input logic wr, input logic [15:0] v);
        req_write = wr;
        req_wdata = v;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        req_valid = 1'b0;
        wait_done(ndone + 1);
    endtask : xfer

    task automatic close_out;
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        // random write then read-back over space, width, pacing and dma
        for (int n = 0; n < 40; n++) begin
            req_mem = 1'($random(seed));
            is_mem = req_mem;
            is_wide = 1'($random(seed));
            req_wide = (n < 2) ? 1'b1 : 1'($random(seed));
            fast = 1'($random(seed));
            stretch = 4'($random(seed));
            req_dma = (n % 8 == 7);
            own_dack = req_dma;
            base = req_mem ? ((n % 2) ? 24'hC40000 : 24'h0D0000) : 24'h000300;
            req_addr = req_mem ? base : {8'h5A, base[15:0]};
            d = 16'($random(seed));
            xfer(1'b1, d);
            check(store, d, req_wide ? 16'hFFFF : 16'h00FF);
            xfer(1'b0, 16'h0000);
            check(got, d, req_wide ? 16'hFFFF : 16'h00FF);
        end
        // back-to-back writes fill the queue behind a slow peripheral
        stretch = 4'hF;
        req_wide = 1'b1;
        is_wide = 1'b1;
        req_dma = 1'b0;
        own_dack = 1'b0;
        seen = 1'b0;
        req_write = 1'b1;
        k = ndone;
        req_valid = 1'b1;
        for (int n = 0; n < 6; n++) begin
            req_wdata = 16'(n + 16'hA50);
            while (req_ready !== 1'b1) begin
                seen = 1'b1;
                @(negedge clk_sys);
            end
            @(negedge clk_sys);
        end
        req_valid = 1'b0;
        check({15'h0000, seen}, 16'h0001, 16'hFFFF);
        wait_done(k + 6);
        xfer(1'b0, 16'h0000);
        check(got, 16'h0A55, 16'hFFFF);
        // a dma cycle without our acknowledge finds nobody answering
        req_dma = 1'b1;
        xfer(1'b0, 16'h0000);
        check(got, 16'hFFFF, 16'hFFFF);
        req_dma = 1'b0;
        // channel error reaches the processor only while checking is on
        err = 1'b1;
        chk_enable = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({15'h0000, nmi}, 16'h0001, 16'hFFFF);
        chk_enable = 1'b0;
        repeat (4) @(negedge clk_sys);
        check({15'h0000, nmi}, 16'h0000, 16'hFFFF);
        err = 1'b0;
        close_out();
    end
endmodule : testbench

// [rtl/isa_bus_if.sv]
interface isa_bus_if;
    logic [19:0] sa;
    logic [6:0]  la;
    logic        bale;
    logic        aen;
    logic        sbhe_n;
    logic        memr_n;
    logic        memw_n;
    logic        smemr_n;
    logic        smemw_n;
    logic        ior_n;
    logic        iow_n;
    logic        refresh_n;
    logic [15:0] sd_host;       // data driven by host
    logic        sd_host_oe;
    logic [15:0] sd_dev;        // data driven by peripheral
    logic        sd_dev_oe;
    logic        iochrdy_low;   // open drain: peripheral pulls low while high
    logic        iochk_low;     // open drain error
    logic        memcs16_low;
    logic        iocs16_low;
    logic        zws_low;
    logic        dack_n;        // peripheral's own dma acknowledge

    // wired bus level seen by both ends
    logic [15:0] sd;
    assign sd = sd_host_oe ? sd_host : (sd_dev_oe ? sd_dev : 16'hFFFF);

    modport host (output sa, la, bale, aen, sbhe_n, memr_n, memw_n, smemr_n, smemw_n,
                  ior_n, iow_n, refresh_n, sd_host, sd_host_oe, dack_n,
                  input sd, iochrdy_low, iochk_low, memcs16_low, iocs16_low, zws_low);
    modport periph (input sa, la, bale, aen, sbhe_n, memr_n, memw_n, smemr_n, smemw_n,
                    ior_n, iow_n, refresh_n, sd, dack_n,
                    output sd_dev, sd_dev_oe, iochrdy_low, iochk_low, memcs16_low,
                    iocs16_low, zws_low);
endinterface : isa_bus_if

// [rtl/isa_cycle_pkg.sv]
package isa_cycle_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int  CLK_MHZ          = 10;
    localparam real REFRESH_US       = 15.6;
    localparam int  REFRESH_CYCLES   = int'(REFRESH_US * CLK_MHZ);   // longest: cast rounds to nearest
    localparam int  WAIT_8BIT        = 4;
    localparam int  WAIT_16BIT       = 1;
    localparam int  REFRESH_LEN      = 4;
    localparam real STRETCH_MAX_US   = 2.5;
    localparam int  STRETCH_MAX      = int'(STRETCH_MAX_US * CLK_MHZ);
    localparam int  FIFO_DEPTH       = 4;

    // ------------------------------------------------------------
    // address layout
    // ------------------------------------------------------------
    localparam int          SA_W       = 20;
    localparam int          LA_LO      = 17;
    localparam int          LA_HI      = 23;
    localparam int          IO_W       = 16;
    localparam logic [23:0] LOW_MEG    = 24'h100000;
    localparam int          REQ_W      = 44;     // {dma, wide, write, mem, data16, addr24}

    // request word packing
    typedef struct packed {
        logic        wide;
        logic        write;
        logic        mem;
        logic [15:0] data;
        logic [23:0] addr;
        logic [0:0]  pad;
    } req_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b011,
        ST_DONE  = 3'b010,
        ST_REF   = 3'b110
    } cyc_state_t;
endpackage : isa_cycle_pkg

// [rtl/isa_host.sv]
// How it works
// RULE1: 8-bit transfers move upper byte onto low lanes
// RULE2: 16-bit to 8-bit device splits into two
// RULE3: I/O uses 16 address bits, memory 24
// RULE4: address valid while address-latch pulse high
// RULE5: one address-latch pulse starts each cycle
// RULE6: byte-high enable low when upper byte used
// RULE7: dma-cycle flag high only during DMA cycles
// RULE8: memory read strobe; low-meg strobe below 1MB
// RULE9: memory write strobe; low-meg strobe below 1MB
// RULE10: I/O strobes stay high during refresh
// RULE11: channel error becomes NMI when enabled
// RULE12: ready low extends the current cycle
// RULE13: peripheral keeps ready low under 2.5 us
// RULE14: memory width from memory 16-bit select
// RULE15: I/O width from I/O 16-bit select
// RULE16: default waits 4 narrow, 1 wide; zero-wait skips
// RULE17: refresh every 15.6 us, refresh line low
// RULE18: split order low byte first, then high
module isa_host
    import isa_cycle_pkg::*;
#(
    parameter int REFRESH_PERIOD = REFRESH_CYCLES
) (
    input  wire logic        clk_sys,     // system clock
    input  wire logic        rst_n,       // async reset, active low
    input  wire logic        req_valid,   // cpu/dma request offered
    output logic             req_ready,   // fifo has room
    input  wire logic        req_mem,     // 1 memory, 0 io
    input  wire logic        req_write,   // 1 write
    input  wire logic        req_wide,    // 16-bit access
    input  wire logic        req_dma,     // request is a dma cycle
    input  wire logic [23:0] req_addr,    // byte address
    input  wire logic [15:0] req_wdata,   // write data
    input  wire logic        chk_enable,  // i/o checking enabled
    output logic             done,        // access finished pulse
    output logic [15:0]      rdata,       // read data, valid with done
    output logic             nmi,         // channel error to processor
    isa_bus_if.host          bus          // expansion bus
);
    // ------------------------------------------------------------
    // request buffer
    // ------------------------------------------------------------
    logic [REQ_W-1:0] fifo_in;
    logic [REQ_W-1:0] head;
    logic           head_valid;
    logic           head_pop;

    assign fifo_in = {req_dma, req_wide, req_write, req_mem, req_wdata, req_addr};

    req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   (fifo_in),
        .out_valid (head_valid),
        .out_ready (head_pop),
        .out_data  (head)
    );

    wire        h_dma   = head[43];
    wire        h_wide  = head[42];
    wire        h_write = head[41];
    wire        h_mem   = head[40];
    wire [15:0] h_data  = head[39:24];
    wire [23:0] h_addr  = head[23:0];

    // io cycles only carry 16 address bits
    function automatic logic [23:0] bus_addr(input logic mem, input logic [23:0] a);
        return mem ? a : {8'h00, a[IO_W-1:0]};                         // RULE3
    endfunction : bus_addr

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    cyc_state_t  state;
    logic        half;          // 0 low byte, 1 high byte of a split
    logic        split;
    logic        wide_cyc;
    logic [3:0]  wait_cnt;
    logic [15:0] ref_cnt;
    logic        ref_due;
    logic [2:0]  ref_len;
    logic [23:0] cur_addr;
    logic        is_low_meg;
    logic        start;
    logic        cmd_on;
    logic [23:0] phase_addr;

    assign start    = (state == ST_IDLE) && head_valid && !ref_due;
    assign head_pop = (state == ST_DONE) && (!split || half);
    assign cur_addr = bus_addr(h_mem, h_addr) + {23'h0, half};       // RULE18
    assign is_low_meg = (cur_addr < LOW_MEG);
    // a command strobe is on the pins
    assign cmd_on     = !(bus.memr_n && bus.memw_n && bus.ior_n && bus.iow_n);
    // address of the phase being set up: the odd half follows the low half
    assign phase_addr = (state == ST_DONE) ? h_addr + 24'h1 : h_addr;

    // refresh interval timer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt <= '0;
            ref_due <= 1'b0;
        end else begin
            if (ref_cnt == 16'(REFRESH_PERIOD - 1)) begin
                ref_cnt <= '0;
                ref_due <= 1'b1;                                       // RULE17
            end else begin
                ref_cnt <= ref_cnt + 1'b1;
            end
            if (state == ST_REF && ref_len == 3'(REFRESH_LEN - 1) && !bus.iochrdy_low) begin
                ref_due <= (ref_cnt == 16'(REFRESH_PERIOD - 1));
            end
        end
    end

    // state walk: addr phase, command with waits, done
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            half     <= 1'b0;
            split    <= 1'b0;
            wide_cyc <= 1'b0;
            wait_cnt <= '0;
            ref_len  <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    half <= 1'b0;
                    if (ref_due) begin
                        state   <= ST_REF;
                        ref_len <= '0;
                    end else if (head_valid) begin
                        state <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    // width decided from the peripheral's select lines
                    wide_cyc <= h_wide && !half && !cur_addr[0]
                                && (h_mem ? bus.memcs16_low : bus.iocs16_low); // RULE14 RULE15
                    split    <= h_wide && !(h_mem ? bus.memcs16_low : bus.iocs16_low); // RULE2
                    wait_cnt <= 4'((h_wide && (h_mem ? bus.memcs16_low : bus.iocs16_low))
                                   ? WAIT_16BIT : WAIT_8BIT);              // RULE16
                    state    <= ST_CMD;
                end
                ST_CMD: begin
                    if (!cmd_on) begin
                        // strobe reaches the pins one clock after entry, so
                        // no answer can be trusted before then
                        state <= ST_CMD;
                    end else if (bus.iochrdy_low) begin
                        state <= ST_CMD;                                   // RULE12
                    end else if (wait_cnt == '0 || bus.zws_low) begin
                        state <= ST_DONE;                                  // RULE16
                    end else begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                ST_DONE: begin
                    if (split && !half) begin
                        half  <= 1'b1;                                     // RULE18
                        state <= ST_ADDR;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_REF: begin
                    if (!bus.iochrdy_low) begin
                        if (ref_len == 3'(REFRESH_LEN - 1)) begin
                            state <= ST_IDLE;
                        end else begin
                            ref_len <= ref_len + 1'b1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bus pins
    // ------------------------------------------------------------
    // address phase outputs and latch pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus.sa     <= '0;
            bus.la     <= '0;
            bus.bale   <= 1'b0;
            bus.aen    <= 1'b0;
            bus.sbhe_n <= 1'b1;
        end else begin
            bus.bale <= (start || (state == ST_DONE && split && !half)); // RULE5 RULE4
            if (state == ST_IDLE || state == ST_DONE) begin
                // next address is set up together with the latch pulse
                bus.sa     <= SA_W'(bus_addr(h_mem, phase_addr));       // RULE3 RULE4
                bus.la     <= 7'(bus_addr(h_mem, phase_addr) >> LA_LO);
                bus.aen    <= head_valid && h_dma && !ref_due;          // RULE7
                // upper byte used for wide access or the odd half
                bus.sbhe_n <= !(h_wide || h_addr[0] || state == ST_DONE); // RULE6
            end
        end
    end

    // command strobes; io strobes never move in refresh
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus.memr_n    <= 1'b1;
            bus.memw_n    <= 1'b1;
            bus.smemr_n   <= 1'b1;
            bus.smemw_n   <= 1'b1;
            bus.ior_n     <= 1'b1;
            bus.iow_n     <= 1'b1;
            bus.refresh_n <= 1'b1;
        end else begin
            bus.memr_n    <= !(state == ST_CMD || state == ST_ADDR) || !h_mem || h_write
                             || (state == ST_ADDR);                    // RULE8
            bus.memw_n    <= !(state == ST_CMD) || !h_mem || !h_write;    // RULE9
            bus.smemr_n   <= !(state == ST_CMD) || !h_mem || h_write || !is_low_meg; // RULE8
            bus.smemw_n   <= !(state == ST_CMD) || !h_mem || !h_write || !is_low_meg; // RULE9
            bus.ior_n     <= !(state == ST_CMD) || h_mem || h_write;      // RULE10
            bus.iow_n     <= !(state == ST_CMD) || h_mem || !h_write;     // RULE10
            bus.refresh_n <= !(state == ST_REF || (state == ST_IDLE && ref_due)); // RULE17
        end
    end

    // write data with upper byte steered down for narrow halves
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus.sd_host    <= '0;
            bus.sd_host_oe <= 1'b0;
            bus.dack_n     <= 1'b1;
        end else begin
            bus.sd_host_oe <= (state == ST_ADDR || state == ST_CMD) && h_write;
            bus.sd_host    <= (half || (!h_wide && h_addr[0]))
                              ? {h_data[15:8], h_data[15:8]} : h_data;   // RULE1
            bus.dack_n     <= !((state == ST_ADDR || state == ST_CMD) && h_dma);
        end
    end

    // read data capture and completion
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
            done  <= 1'b0;
            nmi   <= 1'b0;
        end else begin
            done <= head_pop;
            nmi  <= chk_enable && bus.iochk_low;                        // RULE11
            if (state == ST_CMD && !bus.iochrdy_low && !h_write) begin
                if (wide_cyc) begin
                    rdata <= bus.sd;
                end else if (half) begin
                    rdata[15:8] <= bus.sd[7:0];                         // RULE1
                end else begin
                    rdata[7:0] <= bus.sd[7:0];
                end
            end
        end
    end
endmodule : isa_host

// [rtl/isa_periph.sv]
// ------------------------------------------------------------
// peripheral end: simple register window on the bus
// ------------------------------------------------------------
module isa_periph
    import isa_cycle_pkg::*;
(
    input  wire logic        clk_sys,     // system clock
    input  wire logic        rst_n,       // async reset
    input  wire logic        is_mem,      // decode memory space, else io
    input  wire logic        is_wide,     // 16-bit peripheral
    input  wire logic [23:0] base,        // decode base address (even)
    input  wire logic [3:0]  stretch,     // ready-low cycles per access
    input  wire logic        fast,        // request zero waits
    input  wire logic        err,         // raise channel error
    input  wire logic        own_dack,    // own dma acknowledge active
    output logic [15:0]      store,       // last written word
    output logic             wr_seen,     // write taken pulse
    isa_bus_if.periph        bus          // expansion bus
);
    logic [23:0] lat_addr;
    logic [23:0] dec_addr;
    logic [3:0]  hold;
    logic        hit;
    logic        claim;
    logic        rd_act;
    logic        wr_act;

    // latch is transparent while the pulse is high and holds from its fall
    assign dec_addr = bus.bale ? {bus.la, bus.sa[LA_LO-1:0]} : lat_addr;  // RULE4
    assign hit      = is_mem ? (dec_addr[23:1] == base[23:1])
                             : (dec_addr[15:1] == base[15:1]);           // RULE3
    // a dma cycle is only ours with our own acknowledge
    assign claim    = hit && (!bus.aen || own_dack);                     // RULE7
    assign rd_act   = claim && (is_mem ? !bus.memr_n : !bus.ior_n);
    assign wr_act   = claim && (is_mem ? !bus.memw_n : !bus.iow_n);

    // answers follow the pins within the clock: the host samples the
    // width selects while the latch pulse is still high
    assign bus.memcs16_low = is_wide && is_mem && claim;                 // RULE14
    assign bus.iocs16_low  = is_wide && !is_mem && claim;                // RULE15
    assign bus.iochrdy_low = (rd_act || wr_act) && (hold != 4'h0);       // RULE12
    assign bus.sd_dev_oe   = rd_act;
    assign bus.sd_dev      = (is_wide && !bus.sbhe_n) ? store
                             : {8'h00, (dec_addr[0] ? store[15:8] : store[7:0])};

    // address capture
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lat_addr <= '0;
        end else if (bus.bale) begin
            lat_addr <= {bus.la, bus.sa[LA_LO-1:0]};                      // RULE4
        end
    end

    // ready stretch; a 4-bit count stays below the 2.5 us stretch limit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold <= '0;
        end else if (bus.bale) begin
            hold <= (int'(stretch) > STRETCH_MAX) ? 4'hF : stretch;      // RULE13
        end else if (hold != '0 && (rd_act || wr_act)) begin
            hold <= hold - 1'b1;
        end
    end

    // write capture, error line and zero-wait request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            store         <= '0;
            wr_seen       <= 1'b0;
            bus.iochk_low <= 1'b0;
            bus.zws_low   <= 1'b0;
        end else begin
            wr_seen       <= 1'b0;
            bus.iochk_low <= err;                                        // RULE11
            bus.zws_low   <= fast && claim;                              // RULE16
            if (wr_act && bus.refresh_n) begin
                wr_seen <= 1'b1;
                if (is_wide && !bus.sbhe_n && !dec_addr[0]) begin
                    store <= bus.sd;                                     // RULE6
                end else if (dec_addr[0]) begin
                    store[15:8] <= bus.sd[7:0];                          // RULE1
                end else begin
                    store[7:0] <= bus.sd[7:0];
                end
            end
        end
    end
endmodule : isa_periph

// [rtl/req_fifo.sv]
// ------------------------------------------------------------
// small synchronous fifo, valid/ready both sides
// ------------------------------------------------------------
module req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,   // system clock
    input  wire logic             rst_n,     // async reset
    input  wire logic             in_valid,  // write offer
    output logic                  in_ready,  // room free
    input  wire logic [WIDTH-1:0] in_data,   // write word
    output logic                  out_valid, // word present
    input  wire logic             out_ready, // reader takes
    output logic [WIDTH-1:0]      out_data   // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : req_fifo
